//--- inc/jps_pkg.sv
// Constants, modes and engine states for the programming sequencer.
// Assumes a TAP controller on TCK and an array outside with its write port on mclk and its read port on tck.
//
// What this block does
// - Completion reported through the write-complete poll.
// - Fill update writes buffer, advances word counter.
// - Dump capture loads byte, advances word counter.
// - Page fill never writes EEPROM.
// - Page dump never reads EEPROM.
// - Fuse bit zero programs, one unprograms.
// - Lock bit zero programs, one unchanged.
// - Fill buffer write ends within eleven TCK.
// - Dump alternates low, high; increment after high.
package jps_pkg;
   localparam int           CMD_W        = 15;
   localparam int           STATUS_BIT   = 9;
   localparam logic [6:0]   OP_ENTER     = 7'h01;
   localparam logic [6:0]   OP_LD_AEXT   = 7'h02;
   localparam logic [6:0]   OP_LD_AHI    = 7'h03;
   localparam logic [6:0]   OP_LD_ALO    = 7'h04;
   localparam logic [6:0]   OP_LD_DLO    = 7'h05;
   localparam logic [6:0]   OP_LD_DHI    = 7'h06;
   localparam logic [6:0]   OP_WRITE     = 7'h07;
   localparam logic [6:0]   OP_READ      = 7'h08;
   localparam logic [7:0]   ENTER_FL_WR  = 8'h01;
   localparam logic [7:0]   ENTER_FL_RD  = 8'h02;
   localparam logic [7:0]   ENTER_EE_WR  = 8'h03;
   localparam logic [7:0]   ENTER_EE_RD  = 8'h04;
   localparam logic [7:0]   ENTER_FU_WR  = 8'h05;
   localparam logic [7:0]   ENTER_LK_WR  = 8'h06;
   localparam logic [7:0]   ENTER_FL_RDF = 8'h07;
   localparam logic [7:0]   ENTER_SIG    = 8'h08;
   localparam logic [7:0]   ENTER_CAL    = 8'h09;
   localparam logic [1:0]   RSEL_FLO     = 2'h0;
   localparam logic [1:0]   RSEL_FHI     = 2'h1;
   localparam logic [1:0]   RSEL_LOCK    = 2'h2;
   localparam logic [2:0]   KIND_FLASH   = 3'h0;
   localparam logic [2:0]   KIND_EE      = 3'h1;
   localparam logic [2:0]   KIND_FHI     = 3'h2;
   localparam logic [2:0]   KIND_FLO     = 3'h3;
   localparam logic [2:0]   KIND_LOCK    = 3'h4;
   localparam logic [1:0]   SPC_FLASH    = 2'h0;
   localparam logic [1:0]   SPC_EE       = 2'h1;
   localparam logic [1:0]   SPC_SIG      = 2'h2;
   localparam logic [1:0]   SPC_CAL      = 2'h3;
   localparam int           BUF_AW       = 8;
   localparam logic [8:0]   FLASH_LAST   = 9'h0FF;
   localparam logic [8:0]   EE_LAST      = 9'h007;
   localparam logic [7:0]   FUSE_LO_RST  = 8'hFF;
   localparam logic [7:0]   FUSE_HI_RST  = 8'hFF;
   localparam logic [7:0]   LOCK_RST     = 8'hFF;
   localparam int           FILL_TCK     = 11;
   localparam int           MCLK_MHZ     = 100;
   localparam int           WAIT_US      = 5;
   localparam logic [15:0]  WAIT_CYC     = 16'(WAIT_US * MCLK_MHZ);

   typedef enum logic [9:0] {
      JPS_M_NONE  = 10'h001,
      JPS_M_FL_WR = 10'h002,
      JPS_M_FL_RD = 10'h004,
      JPS_M_EE_WR = 10'h008,
      JPS_M_EE_RD = 10'h010,
      JPS_M_FU_WR = 10'h020,
      JPS_M_LK_WR = 10'h040,
      JPS_M_FU_RD = 10'h080,
      JPS_M_SIG   = 10'h100,
      JPS_M_CAL   = 10'h200
   } jps_mode_t;

   typedef enum logic [2:0] {
      JPS_E_IDLE = 3'h1,
      JPS_E_COPY = 3'h2,
      JPS_E_WAIT = 3'h4
   } jps_eng_t;
endpackage

//--- verilog/jps_buf_ram.sv
// Page buffer: written from the TCK side, read from the mclk side.
// Assumes the reader only reads while the writer is held off by the busy flag.
`timescale 1ns/1ps
`default_nettype none
module jps_buf_ram (
   // Write side.
   input  wire logic                        wclk,
   input  wire logic                        we,
   input  wire logic [jps_pkg::BUF_AW-1:0]  waddr,
   input  wire logic [7:0]                  wdata,
   // Read side.
   input  wire logic                        rclk,
   input  wire logic [jps_pkg::BUF_AW-1:0]  raddr,
   output logic      [7:0]                  rdata
);
   import jps_pkg::*;
   logic [7:0] mem_q [0:(1<<BUF_AW)-1];
   logic [7:0] rdata_q;

   always_ff @(posedge wclk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   always_ff @(posedge rclk) begin
      rdata_q <= mem_q[raddr];
   end

   assign rdata = rdata_q;
endmodule // jps_buf_ram
`default_nettype wire

//--- verilog/jps_nvm_seq.sv
// Programming sequencer behind the JTAG data registers.
// Assumes TAP state strobes arrive on tck; the array write port runs on mclk.
`timescale 1ns/1ps
`default_nettype none
module jps_nvm_seq (
   // Core clock and reset.
   input  wire logic        mclk,
   input  wire logic        reset,
   // TAP side, all on tck.
   input  wire logic        tck,
   input  wire logic        tap_reset,
   input  wire logic        tap_capture,
   input  wire logic        tap_shift,
   input  wire logic        tap_update,
   input  wire logic        nvm_command_instr,
   input  wire logic        page_fill_instr,
   input  wire logic        page_dump_instr,
   input  wire logic        tdi,
   output logic             tdo,
   // Array read port, on tck.
   output logic [23:0]      rd_addr,
   output logic [1:0]       rd_space,
   input  wire logic [15:0] rd_data,
   // Array write port, on mclk.
   output logic             nvm_we,
   output logic             nvm_ee,
   output logic [24:0]      nvm_addr,
   output logic [7:0]       nvm_wdata,
   // Fuse and lock state.
   output logic [7:0]       fuse_lo,
   output logic [7:0]       fuse_hi,
   output logic [7:0]       lock_bits
);
   import jps_pkg::*;

   function automatic jps_mode_t mode_of(input logic [7:0] sel);
      unique case (sel)
         ENTER_FL_WR:  mode_of = JPS_M_FL_WR;
         ENTER_FL_RD:  mode_of = JPS_M_FL_RD;
         ENTER_EE_WR:  mode_of = JPS_M_EE_WR;
         ENTER_EE_RD:  mode_of = JPS_M_EE_RD;
         ENTER_FU_WR:  mode_of = JPS_M_FU_WR;
         ENTER_LK_WR:  mode_of = JPS_M_LK_WR;
         ENTER_FL_RDF: mode_of = JPS_M_FU_RD;
         ENTER_SIG:    mode_of = JPS_M_SIG;
         ENTER_CAL:    mode_of = JPS_M_CAL;
         default:      mode_of = JPS_M_NONE;
      endcase
   endfunction

   // TCK domain state.
   logic [CMD_W-1:0] sh_q, sh_d;
   logic             tdo_q, tdo_d;
   jps_mode_t        mode_q, mode_d;
   logic [23:0]      addr_q, addr_d;
   logic [7:0]       dlo_q, dlo_d, result_q, result_d;
   logic             hi_q, hi_d, first_q, first_d;
   logic             busy_q, busy_d, req_tg_q, req_tg_d;
   logic [2:0]       kind_q, kind_d;
   logic [7:0]       flo_q, flo_d, fhi_q, fhi_d, lock_q, lock_d;
   logic             buf_we_q, buf_we_d;
   logic [7:0]       buf_wa_q, buf_wa_d, buf_wd_q, buf_wd_d;
   logic [1:0]       spc_q, spc_d;
   logic             ack_s1_q, ack_s2_q, ack_s3_q;
   logic             ack_evt;
   logic [6:0]       op;
   logic [7:0]       dat;
   logic             fill_upd, dump_cap;

   // Core domain state.
   jps_eng_t         eng_q, eng_d;
   logic             req_s1_q, req_s2_q, req_s3_q;
   logic             ack_tg_q, ack_tg_d;
   logic [8:0]       cnt_q, cnt_d;
   logic [15:0]      tmr_q, tmr_d;
   logic             rv_q, rv_d;
   logic [7:0]       ridx_q, ridx_d;
   logic             we_q, we_d;
   logic [24:0]      wa_q, wa_d;
   logic [7:0]       wd_q, wd_d;
   logic [7:0]       ram_rdata;
   logic             req_evt, is_ee;
   logic             ee_q, ee_d;

   assign op       = sh_q[14:8];
   assign dat      = sh_q[7:0];
   assign ack_evt  = ack_s2_q ^ ack_s3_q;
   assign fill_upd = tap_update && page_fill_instr && (mode_q == JPS_M_FL_WR);
   assign dump_cap = tap_capture && page_dump_instr && (mode_q == JPS_M_FL_RD);

   always_comb begin
      sh_d     = sh_q;
      mode_d   = mode_q;
      addr_d   = addr_q;
      dlo_d    = dlo_q;
      result_d = result_q;
      hi_d     = hi_q;
      first_d  = first_q;
      busy_d   = busy_q;
      req_tg_d = req_tg_q;
      kind_d   = kind_q;
      flo_d    = flo_q;
      fhi_d    = fhi_q;
      lock_d   = lock_q;
      buf_we_d = 1'b0;
      buf_wa_d = buf_wa_q;
      buf_wd_d = buf_wd_q;
      if (!page_fill_instr && !page_dump_instr) begin
         hi_d    = 1'b0;
         first_d = 1'b1;
      end
      if (tap_capture && nvm_command_instr) begin
         sh_d = {5'h00, ~busy_q, 1'b0, result_q};
      end else if (dump_cap) begin
         sh_d = {7'h00, hi_q ? rd_data[15:8] : rd_data[7:0]};
         hi_d = ~hi_q;
         if (hi_q) begin
            addr_d = addr_q + 24'h000001;
         end
      end else if (tap_shift && nvm_command_instr) begin
         sh_d = {tdi, sh_q[14:1]};
      end else if (tap_shift && (page_fill_instr || page_dump_instr)) begin
         sh_d = {7'h00, tdi, sh_q[7:1]};
      end
      if (fill_upd) begin
         // Low byte of each word after the first moves to the next word first.
         buf_we_d = 1'b1;
         buf_wd_d = sh_q[7:0];
         hi_d     = ~hi_q;
         first_d  = 1'b0;
         if (!hi_q && !first_q) begin
            addr_d   = addr_q + 24'h000001;
            buf_wa_d = {addr_d[6:0], 1'b0};
         end else begin
            buf_wa_d = {addr_q[6:0], hi_q};
         end
      end
      if (tap_update && nvm_command_instr) begin
         unique case (op)
            OP_ENTER:   mode_d = mode_of(dat);
            OP_LD_AEXT: addr_d[23:16] = dat;
            OP_LD_AHI:  addr_d[15:8] = dat;
            OP_LD_ALO:  addr_d[7:0] = dat;
            OP_LD_DLO: begin
               dlo_d = dat;
               if (mode_q == JPS_M_FL_WR || mode_q == JPS_M_EE_WR) begin
                  buf_we_d = 1'b1;
                  buf_wd_d = dat;
                  buf_wa_d = (mode_q == JPS_M_EE_WR) ? {5'h00, addr_q[2:0]} : {addr_q[6:0], 1'b0};
               end
            end
            OP_LD_DHI: begin
               if (mode_q == JPS_M_FL_WR) begin
                  buf_we_d = 1'b1;
                  buf_wd_d = dat;
                  buf_wa_d = {addr_q[6:0], 1'b1};
               end
            end
            OP_WRITE: begin
               if (!busy_q && (mode_q == JPS_M_FL_WR || mode_q == JPS_M_EE_WR ||
                               mode_q == JPS_M_FU_WR || mode_q == JPS_M_LK_WR)) begin
                  busy_d   = 1'b1;
                  req_tg_d = ~req_tg_q;
                  if (mode_q == JPS_M_FL_WR) begin
                     kind_d = KIND_FLASH;
                  end else if (mode_q == JPS_M_EE_WR) begin
                     kind_d = KIND_EE;
                  end else if (mode_q == JPS_M_LK_WR) begin
                     kind_d = KIND_LOCK;
                  end else begin
                     kind_d = dat[0] ? KIND_FHI : KIND_FLO;
                  end
               end
            end
            OP_READ: begin
               if (mode_q == JPS_M_FL_RD) begin
                  result_d = dat[0] ? rd_data[15:8] : rd_data[7:0];
               end else if (mode_q == JPS_M_FU_RD) begin
                  result_d = (dat[1:0] == RSEL_LOCK) ? lock_q :
                             (dat[1:0] == RSEL_FHI) ? fhi_q : flo_q;
               end else if (mode_q == JPS_M_EE_RD || mode_q == JPS_M_SIG || mode_q == JPS_M_CAL) begin
                  result_d = rd_data[7:0];
               end
            end
            default: ;
         endcase
      end
      if (ack_evt) begin
         busy_d = 1'b0;
         if (kind_q == KIND_FLO) begin
            flo_d = dlo_q;
         end else if (kind_q == KIND_FHI) begin
            fhi_d = dlo_q;
         end else if (kind_q == KIND_LOCK) begin
            lock_d = lock_q & dlo_q;
         end
      end
      tdo_d = sh_d[0];
      spc_d = (mode_d == JPS_M_EE_RD) ? SPC_EE : (mode_d == JPS_M_SIG) ? SPC_SIG :
              (mode_d == JPS_M_CAL) ? SPC_CAL : SPC_FLASH;
   end

   always_ff @(posedge tck) begin
      if (tap_reset) begin
         sh_q     <= '0;
         tdo_q    <= 1'b0;
         mode_q   <= JPS_M_NONE;
         addr_q   <= '0;
         dlo_q    <= 8'hFF;
         result_q <= 8'h00;
         hi_q     <= 1'b0;
         first_q  <= 1'b1;
         busy_q   <= 1'b0;
         req_tg_q <= 1'b0;
         kind_q   <= KIND_FLASH;
         flo_q    <= FUSE_LO_RST;
         fhi_q    <= FUSE_HI_RST;
         lock_q   <= LOCK_RST;
         buf_we_q <= 1'b0;
         buf_wa_q <= 8'h00;
         buf_wd_q <= 8'h00;
         spc_q    <= SPC_FLASH;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end else begin
         sh_q     <= sh_d;
         tdo_q    <= tdo_d;
         mode_q   <= mode_d;
         addr_q   <= addr_d;
         dlo_q    <= dlo_d;
         result_q <= result_d;
         hi_q     <= hi_d;
         first_q  <= first_d;
         busy_q   <= busy_d;
         req_tg_q <= req_tg_d;
         kind_q   <= kind_d;
         flo_q    <= flo_d;
         fhi_q    <= fhi_d;
         lock_q   <= lock_d;
         buf_we_q <= buf_we_d;
         buf_wa_q <= buf_wa_d;
         buf_wd_q <= buf_wd_d;
         spc_q    <= spc_d;
         ack_s1_q <= ack_tg_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   jps_buf_ram u_buf (
      .wclk  (tck),
      .we    (buf_we_q),
      .waddr (buf_wa_q),
      .wdata (buf_wd_q),
      .rclk  (mclk),
      .raddr (cnt_q[7:0]),
      .rdata (ram_rdata)
   );

   // Kind is held still by the busy flag until the acknowledge returns; address loads are not gated by it.
   assign req_evt = req_s2_q ^ req_s3_q;
   assign is_ee   = (kind_q == KIND_EE);

   always_comb begin
      eng_d    = eng_q;
      cnt_d    = cnt_q;
      tmr_d    = tmr_q;
      ack_tg_d = ack_tg_q;
      rv_d     = 1'b0;
      ridx_d   = ridx_q;
      we_d     = rv_q;
      wd_d     = ram_rdata;
      ee_d     = is_ee;
      wa_d     = is_ee ? {9'h000, addr_q[15:3], ridx_q[2:0]} : {addr_q[23:7], ridx_q};
      unique case (eng_q)
         JPS_E_IDLE: begin
            cnt_d = 9'h000;
            tmr_d = 16'h0000;
            if (req_evt) begin
               eng_d = (kind_q == KIND_FLASH || is_ee) ? JPS_E_COPY : JPS_E_WAIT;
            end
         end
         JPS_E_COPY: begin
            rv_d   = 1'b1;
            ridx_d = cnt_q[7:0];
            cnt_d  = cnt_q + 9'h001;
            if (cnt_q == (is_ee ? EE_LAST : FLASH_LAST)) begin
               eng_d = JPS_E_WAIT;
            end
         end
         JPS_E_WAIT: begin
            tmr_d = tmr_q + 16'h0001;
            if (tmr_q == WAIT_CYC - 16'h0001) begin
               ack_tg_d = ~ack_tg_q;
               eng_d    = JPS_E_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         eng_q    <= JPS_E_IDLE;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
         ack_tg_q <= 1'b0;
         cnt_q    <= 9'h000;
         tmr_q    <= 16'h0000;
         rv_q     <= 1'b0;
         ridx_q   <= 8'h00;
         we_q     <= 1'b0;
         wa_q     <= '0;
         wd_q     <= 8'h00;
         ee_q     <= 1'b0;
      end else begin
         eng_q    <= eng_d;
         req_s1_q <= req_tg_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
         ack_tg_q <= ack_tg_d;
         cnt_q    <= cnt_d;
         tmr_q    <= tmr_d;
         rv_q     <= rv_d;
         ridx_q   <= ridx_d;
         we_q     <= we_d;
         wa_q     <= wa_d;
         wd_q     <= wd_d;
         ee_q     <= ee_d;
      end
   end

   assign tdo       = tdo_q;
   assign rd_addr   = addr_q;
   assign rd_space  = spc_q;
   assign nvm_we    = we_q;
   assign nvm_ee    = ee_q;
   assign nvm_addr  = wa_q;
   assign nvm_wdata = wd_q;
   assign fuse_lo   = flo_q;
   assign fuse_hi   = fhi_q;
   assign lock_bits = lock_q;

   a_poll_shows_done: assert property (@(posedge tck) disable iff (tap_reset)
      tap_capture && nvm_command_instr |=> sh_q[STATUS_BIT] == !$past(busy_q)) else $error("poll bit wrong");
   a_write_sets_busy: assert property (@(posedge tck) disable iff (tap_reset)
      $rose(busy_q) |-> $changed(req_tg_q)) else $error("busy without request");
   a_fill_buf_write: assert property (@(posedge tck) disable iff (tap_reset)
      fill_upd |=> buf_we_q && buf_wd_q == $past(sh_q[7:0])) else $error("fill byte lost");
   a_fill_lane_toggle: assert property (@(posedge tck) disable iff (tap_reset)
      fill_upd |=> hi_q != $past(hi_q)) else $error("fill lane stuck");
   a_fill_no_ee: assert property (@(posedge tck) disable iff (tap_reset)
      tap_update && page_fill_instr && mode_q == JPS_M_EE_WR |=> !buf_we_q) else $error("fill wrote in EEPROM mode");
   a_dump_no_ee: assert property (@(posedge tck) disable iff (tap_reset)
      tap_capture && page_dump_instr && mode_q != JPS_M_FL_RD && !tap_update
      |=> addr_q == $past(addr_q)) else $error("dump moved address");
   a_dump_inc_high: assert property (@(posedge tck) disable iff (tap_reset)
      dump_cap && !tap_update |=> addr_q == $past(addr_q) + ($past(hi_q) ? 24'h000001 : 24'h000000))
      else $error("dump counter wrong");
   a_fuse_value: assert property (@(posedge tck) disable iff (tap_reset)
      ack_evt && kind_q == KIND_FLO |=> flo_q == $past(dlo_q)) else $error("fuse value wrong");
   a_lock_and_only: assert property (@(posedge tck) disable iff (tap_reset)
      ack_evt && kind_q == KIND_LOCK |=> lock_q == ($past(lock_q) & $past(dlo_q))) else $error("lock value wrong");
   a_wait_length: assert property (@(posedge mclk) disable iff (reset)
      $changed(ack_tg_q) |-> $past(tmr_q) == WAIT_CYC - 16'h0001) else $error("write wait wrong");

   c_page_fill: cover property (@(posedge tck) disable iff (tap_reset) fill_upd && hi_q);
   c_page_dump: cover property (@(posedge tck) disable iff (tap_reset) dump_cap && hi_q);
   c_lock_done: cover property (@(posedge tck) disable iff (tap_reset) ack_evt && kind_q == KIND_LOCK);
   c_ee_copy:   cover property (@(posedge mclk) disable iff (reset) eng_q == JPS_E_COPY && is_ee);
endmodule // jps_nvm_seq
`default_nettype wire

//--- bench/jps_array_model.sv
// Array model on the far side of the sequencer's read and write ports.
// Assumes reads are combinational and writes arrive one per mclk cycle while nvm_we is high.
`timescale 1ns/1ps
`default_nettype none
module jps_array_model #(
   parameter logic [7:0] SIG_BASE = 8'h40, // Arbitrary signature value.
   parameter logic [7:0] CAL_VAL  = 8'h77
) (
   // Read port.
   input  wire logic [23:0] rd_addr,
   input  wire logic [1:0]  rd_space,
   output logic      [15:0] rd_data,
   // Write port.
   input  wire logic        mclk,
   input  wire logic        nvm_we,
   input  wire logic        nvm_ee,
   input  wire logic [24:0] nvm_addr,
   input  wire logic [7:0]  nvm_wdata
);
   // Cells not logged here are taken as erased before any write.
   logic [7:0] fl_mem [int];
   logic [7:0] ee_mem [int];
   always_comb begin
      case (rd_space)
         2'h0:    rd_data = {~rd_addr[7:0], rd_addr[7:0] + 8'h10};
         2'h1:    rd_data = {8'h00, rd_addr[7:0] ^ 8'hC3};
         2'h2:    rd_data = {8'h00, SIG_BASE + rd_addr[7:0]};
         default: rd_data = {8'h00, CAL_VAL};
      endcase
   end
   always @(posedge mclk) begin
      if (nvm_we && nvm_ee) ee_mem[int'(nvm_addr)] = nvm_wdata;
      else if (nvm_we) fl_mem[int'(nvm_addr)] = nvm_wdata;
   end
endmodule // jps_array_model
`default_nettype wire

//--- bench/jps_nvm_seq_tb_top.sv
// Testbench for the programming sequencer: plays the JTAG programmer on tck.
// Assumes jps_array_model answers the read port and logs the array writes.
`timescale 1ns/1ps
`default_nettype none
module jps_nvm_seq_tb_top;
   import jps_pkg::*;
   logic        mclk = 1'b0;
   logic        tck = 1'b0;
   logic        reset = 1'b1;
   logic        tap_reset = 1'b1;
   logic        cap_i = 1'b0;
   logic        shift_i = 1'b0;
   logic        upd_i = 1'b0;
   logic        tdi_i = 1'b0;
   logic [1:0]  instr_i = 2'h0;
   logic        tdo;
   logic [23:0] rd_addr;
   logic [1:0]  rd_space;
   logic [15:0] rd_data;
   logic        nvm_we;
   logic        nvm_ee;
   logic [24:0] nvm_addr;
   logic [7:0]  nvm_wdata;
   logic [7:0]  fuse_lo;
   logic [7:0]  fuse_hi;
   logic [7:0]  lock_bits;
   int          err_count = 0;
   int          checks = 0;
   always #5 mclk = ~mclk;
   always #32 tck = ~tck;
   jps_nvm_seq uut (.mclk(mclk), .reset(reset), .tck(tck), .tap_reset(tap_reset), .tap_capture(cap_i),
      .tap_shift(shift_i), .tap_update(upd_i), .nvm_command_instr(instr_i == 2'h0),
      .page_fill_instr(instr_i == 2'h1), .page_dump_instr(instr_i == 2'h2), .tdi(tdi_i), .tdo(tdo),
      .rd_addr(rd_addr), .rd_space(rd_space), .rd_data(rd_data), .nvm_we(nvm_we), .nvm_ee(nvm_ee),
      .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .fuse_lo(fuse_lo), .fuse_hi(fuse_hi), .lock_bits(lock_bits));
   jps_array_model u_arr (.rd_addr(rd_addr), .rd_space(rd_space), .rd_data(rd_data), .mclk(mclk),
      .nvm_we(nvm_we), .nvm_ee(nvm_ee), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // One tck cycle with the given strobes; always returns at a falling edge.
   task automatic step(input logic c, input logic s, input logic u, input logic d);
      cap_i = c;
      shift_i = s;
      upd_i = u;
      tdi_i = d;
      @(negedge tck);
   endtask
   task automatic cmd(input logic [6:0] op, input logic [7:0] data);
      logic [14:0] v;
      v = {op, data};
      instr_i = 2'h0;
      for (int i = 0; i < 15; i++) step(1'b0, 1'b1, 1'b0, v[i]);
      step(1'b0, 1'b0, 1'b1, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic readout(input int n, output logic [14:0] v);
      v = '0;
      step(1'b1, 1'b0, 1'b0, 1'b0);
      v[0] = tdo;
      for (int i = 1; i < n; i++) begin
         step(1'b0, 1'b1, 1'b0, 1'b0);
         v[i] = tdo;
      end
      step(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic fill(input logic [7:0] b);
      instr_i = 2'h1;
      for (int i = 0; i < 8; i++) step(1'b0, 1'b1, 1'b0, b[i]);
      step(1'b0, 1'b0, 1'b1, 1'b0);
      repeat (FILL_TCK - 9) step(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   // Issues the write, sees busy at once, then polls under a bound.
   task automatic write_wait(input logic [7:0] sel);
      logic [14:0] v;
      int n;
      cmd(OP_WRITE, sel);
      readout(15, v);
      check("done right after write", 16'(v[STATUS_BIT]), 16'h0000);
      n = 0;
      while (v[STATUS_BIT] !== 1'b1 && n < 60) begin
         readout(15, v);
         n++;
      end
      if (v[STATUS_BIT] !== 1'b1) begin
         err_count++;
         $display("unexpected poll: expected done seen busy");
         summarize();
      end
   endtask
   task automatic t_fuse();
      cmd(OP_ENTER, ENTER_FU_WR);
      cmd(OP_LD_DLO, 8'h3C);
      write_wait(8'h01);
      check("fuse_hi", {8'h00, fuse_hi}, 16'h003C);
      check("fuse_lo kept", {8'h00, fuse_lo}, 16'h00FF);
      cmd(OP_LD_DLO, 8'hA5);
      write_wait(8'h00);
      check("fuse_lo", {8'h00, fuse_lo}, 16'h00A5);
      $display("test fuse write done");
   endtask
   task automatic t_lock();
      cmd(OP_ENTER, ENTER_LK_WR);
      cmd(OP_LD_DLO, 8'hF0);
      write_wait(8'h00);
      check("lock_bits first", {8'h00, lock_bits}, 16'h00F0);
      cmd(OP_LD_DLO, 8'h3F);
      cmd(OP_WRITE, 8'h00);
      repeat (120) step(1'b0, 1'b0, 1'b0, 1'b0);
      check("lock_bits second", {8'h00, lock_bits}, 16'h0030);
      $display("test lock write done");
   endtask
   task automatic t_fread();
      logic [14:0] v;
      logic [7:0] exp [3];
      exp = '{8'hA5, 8'h3C, 8'h30};
      cmd(OP_ENTER, ENTER_FL_RDF);
      for (int s = 0; s < 3; s++) begin
         cmd(OP_READ, 8'(s));
         readout(15, v);
         check("fuse or lock read", {8'h00, v[7:0]}, {8'h00, exp[s]});
      end
      $display("test fuse read done");
   endtask
   task automatic t_fill();
      logic [7:0] b [4];
      b = '{8'h11, 8'h22, 8'h33, 8'h44};
      cmd(OP_ENTER, ENTER_FL_WR);
      cmd(OP_LD_AEXT, 8'h00);
      cmd(OP_LD_AHI, 8'h00);
      cmd(OP_LD_ALO, 8'h00);
      for (int i = 0; i < 4; i++) fill(b[i]);
      write_wait(8'h00);
      for (int i = 0; i < 4; i++) check("flash byte", {8'h00, u_arr.fl_mem[i]}, {8'h00, b[i]});
      cmd(OP_ENTER, ENTER_EE_WR);
      cmd(OP_LD_AHI, 8'h00);
      cmd(OP_LD_ALO, 8'h02);
      cmd(OP_LD_DLO, 8'h5C);
      fill(8'h99);
      write_wait(8'h00);
      check("eeprom byte", {8'h00, u_arr.ee_mem[2]}, 16'h005C);
      check("eeprom fill ignored", 16'(u_arr.ee_mem[4] === 8'h99), 16'h0000);
      $display("test page fill done");
   endtask
   task automatic t_dump();
      logic [14:0] v;
      cmd(OP_ENTER, ENTER_FL_RD);
      cmd(OP_LD_AEXT, 8'h00);
      cmd(OP_LD_AHI, 8'h00);
      cmd(OP_LD_ALO, 8'h03);
      cmd(OP_READ, 8'h01);
      readout(15, v);
      check("word read high", {8'h00, v[7:0]}, 16'h00FC);
      cmd(OP_LD_ALO, 8'h00);
      instr_i = 2'h2;
      for (int i = 0; i < 4; i++) begin
         readout(8, v);
         check("dump byte", {8'h00, v[7:0]}, i[0] ? {8'h00, ~8'(i / 2)} : {8'h00, 8'(i / 2) + 8'h10});
      end
      check("dump address", rd_addr[15:0], 16'h0002);
      cmd(OP_ENTER, ENTER_EE_RD);
      cmd(OP_LD_ALO, 8'h05);
      instr_i = 2'h2;
      repeat (2) readout(8, v);
      check("eeprom dump address", rd_addr[15:0], 16'h0005);
      cmd(OP_READ, 8'h00);
      readout(15, v);
      check("eeprom read", {8'h00, v[7:0]}, 16'h00C6);
      $display("test page dump done");
   endtask
   task automatic t_sig();
      logic [14:0] v;
      cmd(OP_ENTER, ENTER_SIG);
      for (int a = 0; a < 3; a++) begin
         cmd(OP_LD_ALO, 8'(a));
         cmd(OP_READ, 8'h00);
         readout(15, v);
         check("signature", {8'h00, v[7:0]}, {8'h00, 8'h40 + 8'(a)});
      end
      cmd(OP_ENTER, ENTER_CAL);
      cmd(OP_LD_ALO, 8'h00);
      cmd(OP_READ, 8'h00);
      readout(15, v);
      check("calibration", {8'h00, v[7:0]}, 16'h0077);
      $display("test signature done");
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      repeat (3) @(negedge tck);
      tap_reset = 1'b0;
      check("fuse_lo reset", {8'h00, fuse_lo}, {8'h00, FUSE_LO_RST});
      t_fuse();
      t_lock();
      t_fread();
      t_fill();
      t_dump();
      t_sig();
      summarize();
   end
endmodule // jps_nvm_seq_tb_top
`default_nettype wire
